// [include/bbs_pkg.sv]
package bbs_pkg;
   // temperatures in degrees F
   localparam logic [7:0] TEMP_SOUP = 8'd185;
   localparam logic [7:0] TEMP_TEA = 8'd170;
   localparam logic [7:0] TEMP_COCOA_PRE = 8'd150;
   localparam logic [7:0] TEMP_WARM = 8'd90;
   localparam logic [7:0] TEMP_POD = 8'd185;
   localparam logic [7:0] TEMP_CUST_MIN = 8'd90;
   localparam logic [7:0] TEMP_CUST_MAX = 8'd185;
   localparam logic [7:0] TEMP_CUST_STEP = 8'd5;
   // durations in seconds
   localparam logic [7:0] VALVE_DELAY_S = 8'd8;
   localparam logic [7:0] PURGE_S = 8'd8;
   localparam logic [7:0] BOOST_S = 8'd2;
   localparam logic [7:0] RELIEF_S = 8'd30;
   localparam logic [7:0] INJECT_S = 8'd1;
   // brew seconds per ounce of serving
   localparam logic [7:0] SEC_PER_OZ = 8'd6;
   // clock and one-second tick
   localparam int CLK_HZ = 40_000_000;
   localparam int TICK_CYC = CLK_HZ;
   localparam logic [25:0] TICK_LAST = 26'(TICK_CYC - 1);
   // preset codes
   typedef enum logic [2:0] {
      BBS_P_SOUP = 3'b000,
      BBS_P_TEA = 3'b001,
      BBS_P_COCOA = 3'b010,
      BBS_P_WARM = 3'b011,
      BBS_P_POD = 3'b100,
      BBS_P_CUSTOM = 3'b101
   } bbs_preset_e;
   // display screens
   typedef enum logic [2:0] {
      BBS_D_HOME = 3'b000,
      BBS_D_SIZE = 3'b001,
      BBS_D_HEAT = 3'b010,
      BBS_D_READY = 3'b011,
      BBS_D_BREW = 3'b100,
      BBS_D_DONE = 3'b101
   } bbs_disp_e;
   // diagnostic heat names
   typedef enum logic [1:0] {
      BBS_H_OFF = 2'b00,
      BBS_H_LOW = 2'b01,
      BBS_H_TURBO = 2'b10
   } bbs_heat_e;
endpackage

// [rtl/bbs_tick.sv]
`timescale 1ns/1ps
// one-second timebase; restarts on clear so intervals start aligned
module bbs_tick
   import bbs_pkg::*;
(
   // clock and control
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic ce,
   input wire logic clr,
   // output
   output logic tick
);
   typedef struct packed {
      logic [25:0] cnt;
   } bbs_tick_s;
   bbs_tick_s st_reg, st_next;

   // free counter, cleared at each phase change
   always_comb begin
      st_next = st_reg;
      if (clr || st_reg.cnt == TICK_LAST) begin
         st_next.cnt = '0;
      end else begin
         st_next.cnt = st_reg.cnt + 26'd1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         st_reg <= '0;
      end else if (ce) begin
         st_reg <= st_next;
      end
   end

   // no path from clr to tick: clr comes from the sequencer's next state,
   // which itself depends on tick, so gating here would close a loop
   assign tick = ce && st_reg.cnt == TICK_LAST;
endmodule

// [rtl/bbs_sequencer.sv]
`timescale 1ns/1ps
// hot-water tank and pod brew sequencer
module bbs_sequencer
   import bbs_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic ce,
   // user controls, one-cycle pulses except levels noted
   input wire logic hw_button,
   input wire logic [2:0] preset_sel,
   input wire logic preset_go,
   input wire logic cust_up,
   input wire logic cust_down,
   input wire logic module_installed,
   input wire logic bev_cocoa,
   input wire logic bev_go,
   input wire logic [3:0] size_oz,
   input wire logic size_go,
   input wire logic knob_release,
   input wire logic cancel,
   // appliance state, levels
   input wire logic sabbath_mode,
   input wire logic demo_mode,
   input wire logic service_mode,
   input wire logic compressor_on,
   input wire logic icemaker_on,
   input wire logic defrost_on,
   input wire logic [7:0] water_temp,
   // display
   output logic [2:0] screen,
   output logic slow_notice,
   output logic [1:0] heat_diag,
   output logic [7:0] target_temp,
   // actuators
   output logic supply_relay,
   output logic bypass_relay,
   output logic vent_valves,
   output logic air_pump,
   output logic pump_boost,
   output logic nozzle_down,
   output logic iso_valve,
   output logic brew_valve,
   output logic outlet_valve
);
   typedef enum logic [3:0] {
      S_IDLE = 4'b0000,
      S_MENU = 4'b0001,
      S_SIZE = 4'b0010,
      S_HEAT = 4'b0011,
      S_READY = 4'b0100,
      S_PRIME = 4'b0101,
      S_FLOW = 4'b0110,
      S_PURGE = 4'b0111,
      S_RELIEF = 4'b1000,
      S_WHEAT = 4'b1001
   } bbs_state_e;

   typedef struct packed {
      bbs_state_e state;
      logic [7:0] secs;
      logic [7:0] brew_len;
      logic [7:0] cust;
      logic [7:0] target;
      logic cocoa;
      logic bev_ok;
      logic [2:0] screen;
      logic slow;
      logic [1:0] heat;
      logic supply;
      logic bypass;
      logic vents;
      logic pump;
      logic boost;
      logic nozzle;
      logic iso;
      logic brew;
      logic outlet;
   } bbs_seq_s;

   bbs_seq_s st_reg, st_next;
   logic tick;
   logic phase_clr;
   logic blocked;
   logic low_pwr;

   // target for a fixed preset
   function automatic logic [7:0] preset_temp(input logic [2:0] p,
                                              input logic [7:0] c);
      case (p)
         BBS_P_SOUP: preset_temp = TEMP_SOUP;
         BBS_P_TEA: preset_temp = TEMP_TEA;
         BBS_P_COCOA: preset_temp = TEMP_COCOA_PRE;
         BBS_P_WARM: preset_temp = TEMP_WARM;
         BBS_P_POD: preset_temp = TEMP_POD;
         default: preset_temp = c;
      endcase
   endfunction

   // valid serving size
   function automatic logic size_ok(input logic [3:0] oz);
      size_ok = (oz == 4'd6) || (oz == 4'd8) || (oz == 4'd10);
   endfunction

   bbs_tick u_tick (
      .clk_sys(clk_sys),
      .rst(rst),
      .ce(ce),
      .clr(phase_clr),
      .tick(tick)
   );

   assign blocked = sabbath_mode || demo_mode || service_mode;
   assign low_pwr = compressor_on || icemaker_on || defrost_on;
   assign phase_clr = st_next.state != st_reg.state;

   // sequence and actuator state
   always_comb begin
      st_next = st_reg;
      if (tick) begin
         st_next.secs = st_reg.secs + 8'd1;
      end
      if (st_next.state != st_reg.state) begin
         st_next.secs = '0;
      end
      // custom temperature stays on the 5 degree grid
      if (cust_up && st_reg.cust <= TEMP_CUST_MAX - TEMP_CUST_STEP) begin
         st_next.cust = st_reg.cust + TEMP_CUST_STEP;
      end else if (cust_down &&
                   st_reg.cust >= TEMP_CUST_MIN + TEMP_CUST_STEP) begin
         st_next.cust = st_reg.cust - TEMP_CUST_STEP;
      end
      case (st_reg.state)
         S_IDLE: begin
            if (module_installed) begin
               st_next.state = S_SIZE;
               st_next.bev_ok = 1'b0;
            end else if (hw_button) begin
               st_next.state = S_MENU;
            end
         end
         S_MENU: begin
            if (module_installed || (preset_go && preset_sel == BBS_P_POD)) begin
               st_next.state = S_SIZE;
               st_next.bev_ok = 1'b0;
            end else if (preset_go) begin
               st_next.target = preset_temp(preset_sel, st_reg.cust);
               st_next.state = S_WHEAT;
            end
         end
         S_SIZE: begin
            if (bev_go) begin
               st_next.cocoa = bev_cocoa;
               st_next.bev_ok = 1'b1;
            end
            // both beverage and size needed before heating
            if (size_go && size_ok(size_oz) && (st_reg.bev_ok || bev_go)) begin
               st_next.state = S_HEAT;
               st_next.target = TEMP_POD;
               st_next.brew_len = 8'(size_oz * SEC_PER_OZ);
            end
         end
         S_HEAT, S_WHEAT: begin
            if (water_temp >= st_reg.target) begin
               st_next.state = (st_reg.state == S_HEAT) ? S_READY : S_IDLE;
            end
         end
         S_READY: begin
            if (knob_release) begin
               st_next.state = S_PRIME;
            end
         end
         S_PRIME: begin
            if (tick && st_reg.secs == VALVE_DELAY_S - 8'd1) begin
               st_next.state = S_FLOW;
            end
         end
         S_FLOW: begin
            if (tick && st_reg.secs == st_reg.brew_len - 8'd1) begin
               st_next.state = S_PURGE;
            end
         end
         S_PURGE: begin
            if (tick && st_reg.secs == PURGE_S - 8'd1) begin
               st_next.state = S_RELIEF;
            end
         end
         S_RELIEF: begin
            if (tick && st_reg.secs == RELIEF_S - 8'd1) begin
               st_next.state = S_IDLE;
            end
         end
         default: st_next.state = S_IDLE;
      endcase
      // cancel or a blocking mode abandons any hot-water activity
      if (blocked || (cancel && st_reg.state != S_IDLE)) begin
         st_next.state = S_IDLE;
      end
      if (st_next.state != st_reg.state) begin
         st_next.secs = '0;
      end
      // actuators follow the next state so they line up with it
      st_next.supply = 1'b0;
      st_next.bypass = 1'b0;
      st_next.slow = 1'b0;
      st_next.heat = BBS_H_OFF;
      st_next.vents = 1'b0;
      st_next.pump = 1'b0;
      st_next.boost = 1'b0;
      st_next.nozzle = 1'b0;
      st_next.iso = 1'b0;
      st_next.brew = 1'b0;
      st_next.outlet = 1'b0;
      st_next.screen = BBS_D_HOME;
      case (st_next.state)
         S_SIZE: st_next.screen = BBS_D_SIZE;
         S_HEAT, S_WHEAT: begin
            st_next.screen = BBS_D_HEAT;
            st_next.vents = st_next.state == S_HEAT;
            st_next.supply = 1'b1;
            st_next.bypass = !low_pwr;
            st_next.slow = low_pwr;
            st_next.heat = low_pwr ? BBS_H_LOW : BBS_H_TURBO;
         end
         S_READY: begin
            st_next.screen = BBS_D_READY;
            st_next.vents = 1'b1;
         end
         S_PRIME: begin
            st_next.screen = BBS_D_BREW;
            st_next.pump = 1'b1;
            st_next.nozzle = 1'b1;
            st_next.iso = 1'b1;
         end
         S_FLOW: begin
            st_next.screen = BBS_D_BREW;
            st_next.pump = 1'b1;
            st_next.nozzle = 1'b1;
            st_next.iso = 1'b1;
            st_next.brew = 1'b1;
            // cocoa air shot around the dispense midpoint
            st_next.outlet = st_reg.cocoa &&
               st_next.secs >= (st_reg.brew_len >> 1) &&
               st_next.secs < (st_reg.brew_len >> 1) + INJECT_S;
         end
         S_PURGE: begin
            st_next.screen = BBS_D_BREW;
            st_next.pump = 1'b1;
            st_next.nozzle = 1'b1;
            st_next.outlet = 1'b1;
            st_next.boost = st_reg.cocoa &&
               st_next.secs >= PURGE_S - BOOST_S;
         end
         S_RELIEF: begin
            st_next.screen = BBS_D_DONE;
            st_next.vents = 1'b1;
            st_next.outlet = 1'b1;
         end
         default: st_next.screen = BBS_D_HOME;
      endcase
   end

   // one register for all state; ce freezes everything
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         st_reg <= '0;
         st_reg.state <= S_IDLE;
         st_reg.cust <= TEMP_CUST_MIN;
         st_reg.target <= TEMP_WARM;
      end else if (ce) begin
         st_reg <= st_next;
      end
   end

   assign screen = st_reg.screen;
   assign slow_notice = st_reg.slow;
   assign heat_diag = st_reg.heat;
   assign target_temp = st_reg.target;
   assign supply_relay = st_reg.supply;
   assign bypass_relay = st_reg.bypass;
   assign vent_valves = st_reg.vents;
   assign air_pump = st_reg.pump;
   assign pump_boost = st_reg.boost;
   assign nozzle_down = st_reg.nozzle;
   assign iso_valve = st_reg.iso;
   assign brew_valve = st_reg.brew;
   assign outlet_valve = st_reg.outlet;

   // checks
   a_bypass_full_power: assert property (@(posedge clk_sys)
      disable iff (rst)
      bypass_relay |-> supply_relay && heat_diag == BBS_H_TURBO)
      else $error("bypass closed without turbo heating");
   a_slow_notice_low: assert property (@(posedge clk_sys)
      disable iff (rst) slow_notice == (heat_diag == BBS_H_LOW))
      else $error("slow notice mismatch");
   a_brew_needs_pump: assert property (@(posedge clk_sys)
      disable iff (rst) brew_valve |-> air_pump && iso_valve && nozzle_down)
      else $error("brew valve open without pump");
   a_purge_outlet_open: assert property (@(posedge clk_sys)
      disable iff (rst)
      (air_pump && !iso_valve && st_reg.state == S_PURGE) |-> outlet_valve)
      else $error("purge without outlet");
   a_boost_cocoa_only: assert property (@(posedge clk_sys)
      disable iff (rst) pump_boost |-> st_reg.cocoa && air_pump && !brew_valve)
      else $error("boost outside cocoa purge");
   a_cust_on_grid: assert property (@(posedge clk_sys)
      disable iff (rst)
      st_reg.cust >= TEMP_CUST_MIN && st_reg.cust <= TEMP_CUST_MAX &&
      (st_reg.cust - TEMP_CUST_MIN) % TEMP_CUST_STEP == 8'h00)
      else $error("custom temp off the 5 degree grid");
   a_blocked_idle: assert property (@(posedge clk_sys)
      disable iff (rst)
      (ce && blocked) |=> st_reg.state == S_IDLE && !supply_relay)
      else $error("active in blocked mode");
   a_knob_starts_brew: assert property (@(posedge clk_sys)
      disable iff (rst)
      (ce && st_reg.state == S_READY && knob_release && !blocked && !cancel)
      |=> air_pump && screen == BBS_D_BREW && !vent_valves)
      else $error("brew did not start");
   a_relief_valves: assert property (@(posedge clk_sys)
      disable iff (rst)
      screen == BBS_D_DONE |-> vent_valves && outlet_valve && !air_pump)
      else $error("relief valves not open");
   a_idle_rest: assert property (@(posedge clk_sys)
      disable iff (rst)
      st_reg.state == S_IDLE |-> !(air_pump || vent_valves || outlet_valve
      || iso_valve || brew_valve || supply_relay))
      else $error("actuator active in idle");
endmodule

// [test/bbs_tank_model.sv]
`timescale 1ns/1ps
// behavioural tank: warms one degree per 4 cycles with the diode bypassed,
// per 8 cycles through the diode; starts cold so every heat phase is real
module bbs_tank_model (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // heater drive
   input wire logic supply_relay,
   input wire logic bypass_relay,
   // sensed temperature
   output logic [7:0] water_temp
);
   logic [2:0] div_reg;
   // slow rates keep heating long enough to probe power changes mid-phase
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         div_reg <= 3'h0;
         water_temp <= 8'h3c;
      end else begin
         div_reg <= div_reg + 3'h1;
         if (supply_relay && (div_reg == 3'h0 ||
             (bypass_relay && div_reg == 3'h4)) && water_temp != 8'hff) begin
            water_temp <= water_temp + 8'h01;
         end
      end
   end
endmodule

// [test/bbs_sequencer_tb_top.sv]
`timescale 1ns/1ps
// bench for the brew sequencer; the one-second tick is far beyond this run,
// so only the untimed steps of a brew are probed
module bbs_sequencer_tb_top
   import bbs_pkg::*;
;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic ce = 1'b1;
   logic [8:0] pls = 9'h000;
   logic [2:0] preset_sel = 3'h0;
   logic [3:0] size_oz = 4'h0;
   logic bev_cocoa = 1'b0;
   logic [2:0] mode = 3'h0;
   logic [2:0] dem = 3'h0;
   logic [7:0] water_temp, target_temp, exp_t;
   logic [2:0] screen;
   logic [1:0] heat_diag;
   logic slow_notice, supply_relay, bypass_relay, vent_valves, air_pump;
   logic pump_boost, nozzle_down, iso_valve, brew_valve, outlet_valve;
   logic low, up;
   int n_mismatch = 0;
   int total_checks = 0;
   int r;

   always #12.5 clk_sys = ~clk_sys;

   bbs_sequencer DUT (.clk_sys(clk_sys), .rst(rst), .ce(ce),
      .hw_button(pls[0]), .preset_sel(preset_sel), .preset_go(pls[1]),
      .cust_up(pls[2]), .cust_down(pls[3]), .module_installed(pls[4]),
      .bev_cocoa(bev_cocoa), .bev_go(pls[5]), .size_oz(size_oz),
      .size_go(pls[6]), .knob_release(pls[7]), .cancel(pls[8]),
      .sabbath_mode(mode[0]), .demo_mode(mode[1]), .service_mode(mode[2]),
      .compressor_on(dem[0]), .icemaker_on(dem[1]), .defrost_on(dem[2]),
      .water_temp(water_temp), .screen(screen), .slow_notice(slow_notice),
      .heat_diag(heat_diag), .target_temp(target_temp),
      .supply_relay(supply_relay), .bypass_relay(bypass_relay),
      .vent_valves(vent_valves), .air_pump(air_pump),
      .pump_boost(pump_boost), .nozzle_down(nozzle_down),
      .iso_valve(iso_valve), .brew_valve(brew_valve),
      .outlet_valve(outlet_valve));

   bbs_tank_model tank (.clk_sys(clk_sys), .rst(rst),
      .supply_relay(supply_relay), .bypass_relay(bypass_relay),
      .water_temp(water_temp));

   task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected %s: expected %0h seen %0h", what, exp, got);
      end
   endtask

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // one-cycle pulse; the data lanes ride along, only read with their strobe
   task automatic pulse(int b, logic [3:0] d = 4'h0);
      @(posedge clk_sys);
      pls[b] <= 1'b1;
      preset_sel <= d[2:0];
      size_oz <= d;
      @(posedge clk_sys);
      pls[b] <= 1'b0;
      #1;
   endtask

   // bounded wait; running out ends the run
   task automatic wait_scr(logic [2:0] s, int bound);
      int i;
      i = 0;
      while (screen !== s && i < bound) begin
         @(posedge clk_sys);
         #1;
         i++;
      end
      chk("screen wait", 8'(s), 8'(screen));
      if (screen !== s) begin
         print_verdict();
      end
   endtask

   function automatic logic [7:0] preset_temp(logic [2:0] p);
      case (p)
         BBS_P_SOUP: return TEMP_SOUP;
         BBS_P_TEA: return TEMP_TEA;
         BBS_P_COCOA: return TEMP_COCOA_PRE;
         default: return TEMP_WARM;
      endcase
   endfunction

   // custom steps clamp at both ends of the range
   function automatic logic [7:0] cust_step(logic [7:0] t, logic u);
      if (u) return (t >= TEMP_CUST_MAX) ? TEMP_CUST_MAX : t + TEMP_CUST_STEP;
      return (t <= TEMP_CUST_MIN) ? TEMP_CUST_MIN : t - TEMP_CUST_STEP;
   endfunction

   initial begin
      r = $urandom(73);
      repeat (5) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      #1;
      chk("reset screen", 8'(BBS_D_HOME), 8'(screen));
      chk("reset target", TEMP_CUST_MIN, target_temp);
      // fixed presets, tank still cold
      for (int p = 0; p < 4; p++) begin
         pulse(0);
         pulse(1, 4'(p));
         chk("preset target", preset_temp(3'(p)), target_temp);
         chk("preset heater", 8'h01, 8'(supply_relay));
         pulse(8);
      end
      pulse(0);
      pulse(1, 4'(BBS_P_POD));
      chk("pod preset", 8'(BBS_D_SIZE), 8'(screen));
      pulse(8);
      $display("test presets done");
      // custom temperature, driven into both clamps then at random
      exp_t = TEMP_CUST_MIN;
      for (int k = 0; k < 60; k++) begin
         up = (k < 22) ? 1'b1 : (k < 44) ? 1'b0 : 1'($urandom_range(1));
         pulse(up ? 2 : 3);
         exp_t = cust_step(exp_t, up);
      end
      pulse(0);
      pulse(1, 4'(BBS_P_CUSTOM));
      chk("custom target", exp_t, target_temp);
      pulse(8);
      $display("test custom done");
      // each blocking mode stops heating and ignores the brew module
      for (int m = 0; m < 3; m++) begin
         pulse(0);
         pulse(1, 4'(BBS_P_TEA));
         @(posedge clk_sys);
         mode <= 3'(1 << m);
         repeat (2) @(posedge clk_sys);
         #1;
         chk("blocked screen", 8'(BBS_D_HOME), 8'(screen));
         chk("blocked heater", 8'h00, 8'(supply_relay));
         pulse(4);
         chk("blocked install", 8'(BBS_D_HOME), 8'(screen));
         @(posedge clk_sys);
         mode <= 3'h0;
      end
      $display("test modes done");
      // pod flow from module install; size refused without beverage or odd
      pulse(4);
      chk("install screen", 8'(BBS_D_SIZE), 8'(screen));
      pulse(6, 4'h8);
      chk("no beverage", 8'(BBS_D_SIZE), 8'(screen));
      @(posedge clk_sys);
      bev_cocoa <= 1'($urandom_range(1));
      pulse(5);
      pulse(6, 4'h7);
      chk("odd size", 8'(BBS_D_SIZE), 8'(screen));
      chk("odd size heater", 8'h00, 8'(supply_relay));
      r = $urandom_range(2);
      pulse(6, 4'(6 + 2 * r));
      chk("size screen", 8'(BBS_D_HEAT), 8'(screen));
      chk("vents open", 8'h01, 8'(vent_valves));
      chk("pod target", TEMP_POD, target_temp);
      pulse(7);
      chk("knob early", 8'(BBS_D_HEAT), 8'(screen));
      // power demand changes while heating
      for (int k = 0; k < 24; k++) begin
         @(posedge clk_sys);
         dem <= (k < 3) ? 3'(1 << k) : 3'($urandom_range(7));
         @(posedge clk_sys);
         #1;
         low = |dem;
         chk("heater", 8'h01, 8'(supply_relay));
         chk("bypass", 8'(!low), 8'(bypass_relay));
         chk("notice", 8'(low), 8'(slow_notice));
         chk("diag", 8'(low ? BBS_H_LOW : BBS_H_TURBO), 8'(heat_diag));
      end
      @(posedge clk_sys);
      dem <= 3'h0;
      wait_scr(BBS_D_READY, 2000);
      chk("ready heater", 8'h00, 8'(supply_relay));
      chk("ready diag", 8'(BBS_H_OFF), 8'(heat_diag));
      chk("ready vents", 8'h01, 8'(vent_valves));
      $display("test heating done");
      // brew start
      pulse(7);
      chk("brew screen", 8'(BBS_D_BREW), 8'(screen));
      chk("pump", 8'h01, 8'(air_pump));
      chk("vents shut", 8'h00, 8'(vent_valves));
      chk("nozzle", 8'h01, 8'(nozzle_down));
      chk("isolation", 8'h01, 8'(iso_valve));
      repeat (40) @(posedge clk_sys);
      #1;
      chk("water valve early", 8'h00, 8'(brew_valve));
      chk("outlet early", 8'h00, 8'(outlet_valve));
      chk("boost early", 8'h00, 8'(pump_boost));
      pulse(8);
      chk("cancel screen", 8'(BBS_D_HOME), 8'(screen));
      chk("cancel pump", 8'h00, 8'(air_pump));
      chk("cancel nozzle", 8'h00, 8'(nozzle_down));
      chk("cancel isolation", 8'h00, 8'(iso_valve));
      $display("test brew start done");
      // ce low freezes all state, so an install pulse is lost
      @(posedge clk_sys);
      ce <= 1'b0;
      pulse(4);
      chk("frozen screen", 8'(BBS_D_HOME), 8'(screen));
      @(posedge clk_sys);
      ce <= 1'b1;
      pulse(4);
      chk("thawed install", 8'(BBS_D_SIZE), 8'(screen));
      $display("test clock enable done");
      print_verdict();
   end
endmodule
